// ==== irwt_pkg.sv ====
// Shared constants and types for the two-wire register write target.
// Assumes a single mclk domain for the core and the serial clock as a
// second domain used only for bit sampling.
package irwt_pkg;

  // Bits that make up one byte on the serial data line.
  localparam int unsigned BYTE_BITS     = 8;

  // Bit counter value after the last data bit of a byte has been clocked.
  localparam logic [3:0]  CNT_ACK_SLOT  = 4'h8;

  // Bit counter value while the last data bit of a byte is being clocked.
  localparam logic [3:0]  CNT_LAST_BIT  = 4'h7;

  // Bit counter value at the start of every byte.
  localparam logic [3:0]  CNT_ZERO      = 4'h0;

  // Bit counter increment.
  localparam logic [3:0]  CNT_STEP      = 4'h1;

  // Fixed seven-bit target address.
  localparam logic [6:0]  TARGET_ADDR   = 7'h38;

  // Direction bit codes.
  localparam logic        DIR_WRITE     = 1'b0;
  localparam logic        DIR_READ      = 1'b1;

  // Full address bytes with the direction bit appended.
  localparam logic [7:0]  ADDR_BYTE_WR  = {TARGET_ADDR, DIR_WRITE};
  localparam logic [7:0]  ADDR_BYTE_RD  = {TARGET_ADDR, DIR_READ};

  // Reset value of every byte wide register.
  localparam logic [7:0]  BYTE_RESET    = 8'h00;

  // Transfer phases of the target.
  typedef enum logic [2:0] {
    IRWT_IDLE,
    IRWT_ADDR,
    IRWT_INDEX,
    IRWT_DATA,
    IRWT_READ,
    IRWT_IGNORE
  } irwt_phase_t;

endpackage : irwt_pkg

// ==== irwt_bit_if.sv ====
// Carrier for sampled serial bits from the serial clock domain to the core.
// Assumes the bit value is held stable between two serial clock rises.
interface irwt_bit_if;

  logic bit_val;   // Data line level captured at the latest serial clock rise.
  logic bit_tog;   // Toggles once per serial clock rise.

  // Serial clock side, which produces the bits.
  modport link (
    output bit_val,
    output bit_tog
  );

  // Core side, which consumes them after synchronising the toggle.
  modport core (
    input  bit_val,
    input  bit_tog
  );

endinterface : irwt_bit_if

// ==== irwt_bit_sampler.sv ====
// Serial clock domain sampler: captures the data line on each serial clock
// rise and flags the capture with a toggle.
// Assumes an asynchronous reset that is released while the serial clock is idle.
module irwt_bit_sampler (
  input  wire logic  scl,
  input  wire logic  link_rst_n,
  input  wire logic  sda_i,
  irwt_bit_if.link   bits
);

  logic bit_q;   // Captured data line level.
  logic bit_d;   // Next captured level.
  logic tog_q;   // Capture toggle.
  logic tog_d;   // Next capture toggle.

  // Every rise takes a fresh sample; the core reads the bit only after the
  // toggle has crossed, and the bit cannot change again until the next rise.
  always_comb begin
    bit_d = sda_i;
    tog_d = ~tog_q;
  end

  // The link clock may stand still, so the reset must act without it.
  always_ff @(posedge scl or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bit_q <= 1'b0;
      tog_q <= 1'b0;
    end else begin
      bit_q <= bit_d;
      tog_q <= tog_d;
    end
  end

  assign bits.bit_val = bit_q;
  assign bits.bit_tog = tog_q;

endmodule // irwt_bit_sampler

// ==== irwt_target.sv ====
// Two-wire serial target that lets an external master write and read back
// the device's internal byte registers.
// Assumes the register store sits outside on mclk and answers reg_rdata for
// reg_addr with no latency; serial pins arrive asynchronously to mclk.
//
// Operation
// - Data falling while clock high starts session
// - Data rising while clock high stops session
// - Bus busy from start until stop
// - Repeated start restarts address reception
// - Data changes only while clock is low
// - Respond only to seven-bit address 0x38
// - Direction bit zero writes, one reads
// - First byte after address selects register
// - Following byte is stored into register
// - Bytes are eight bits, MSB first
// - Target pulls data low on ninth pulse
// - Address byte 0x70 writes, 0x71 reads
module irwt_target
  import irwt_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        scl,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  output logic             bus_busy,
  output logic [7:0]       reg_addr,
  output logic [7:0]       reg_wdata,
  output logic             reg_wr,
  input  wire logic [7:0]  reg_rdata
);

  // Reset for the serial clock domain.

  logic link_rst_n_q;   // Low during reset, high after the first released edge.
  logic link_rst_n_d;   // Next value of the link reset.

  // The link reset is a flop output so the sampler never sees a glitch.
  always_comb begin
    link_rst_n_d = 1'b1;
  end

  // Synchronous reset drives the link reset low for the whole reset time.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      link_rst_n_q <= 1'b0;
    end else begin
      link_rst_n_q <= link_rst_n_d;
    end
  end

  // Serial clock domain sampler.

  irwt_bit_if bit_link ();   // Carries each sampled bit into the core.

  irwt_bit_sampler u_sampler (
    .scl        (scl),
    .link_rst_n (link_rst_n_q),
    .sda_i      (sda_i),
    .bits       (bit_link.link)
  );

  // Synchronisers for the pins and the bit toggle.

  logic scl_s1_q;   // First stage, read only by the second stage.
  logic scl_s2_q;   // Synchronised clock level.
  logic scl_s3_q;   // Previous synchronised clock level.
  logic sda_s1_q;   // First stage, read only by the second stage.
  logic sda_s2_q;   // Synchronised data level.
  logic sda_s3_q;   // Previous synchronised data level.
  logic tog_s1_q;   // First stage, read only by the second stage.
  logic tog_s2_q;   // Synchronised bit toggle.
  logic tog_s3_q;   // Previous synchronised bit toggle.
  logic scl_s1_d;
  logic scl_s2_d;
  logic scl_s3_d;
  logic sda_s1_d;
  logic sda_s2_d;
  logic sda_s3_d;
  logic tog_s1_d;
  logic tog_s2_d;
  logic tog_s3_d;

  // Each chain is two flops deep before any logic looks at it; the third
  // flop only keeps the previous settled value for edge detection.
  always_comb begin
    scl_s1_d = scl;
    scl_s2_d = scl_s1_q;
    scl_s3_d = scl_s2_q;
    sda_s1_d = sda_i;
    sda_s2_d = sda_s1_q;
    sda_s3_d = sda_s2_q;
    tog_s1_d = bit_link.bit_tog;
    tog_s2_d = tog_s1_q;
    tog_s3_d = tog_s2_q;
  end

  // An idle bus floats high, so the pin chains reset to one.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_s3_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
      tog_s1_q <= 1'b0;
      tog_s2_q <= 1'b0;
      tog_s3_q <= 1'b0;
    end else begin
      scl_s1_q <= scl_s1_d;
      scl_s2_q <= scl_s2_d;
      scl_s3_q <= scl_s3_d;
      sda_s1_q <= sda_s1_d;
      sda_s2_q <= sda_s2_d;
      sda_s3_q <= sda_s3_d;
      tog_s1_q <= tog_s1_d;
      tog_s2_q <= tog_s2_d;
      tog_s3_q <= tog_s3_d;
    end
  end

  // Bus events, all derived from settled values.

  logic start_evt;   // Start or repeated start seen.
  logic stop_evt;    // Stop seen.
  logic rise_evt;    // A sampled bit has arrived from the link domain.
  logic fall_evt;    // Serial clock has gone low.

  always_comb begin
    start_evt = scl_s2_q && scl_s3_q && sda_s3_q && !sda_s2_q;
    stop_evt  = scl_s2_q && scl_s3_q && !sda_s3_q && sda_s2_q;
    rise_evt  = tog_s2_q ^ tog_s3_q;
    fall_evt  = scl_s3_q && !scl_s2_q;
  end

  // Protocol engine.

  irwt_phase_t phase_q;    // Transfer phase.
  irwt_phase_t phase_d;
  logic [3:0]  cnt_q;      // Bits clocked in the current byte.
  logic [3:0]  cnt_d;
  logic [7:0]  rx_q;       // Receive shift register.
  logic [7:0]  rx_d;
  logic [7:0]  rx_byte;    // Receive register with the newest bit appended.
  logic [7:0]  tx_q;       // Transmit shift register, MSB leaves first.
  logic [7:0]  tx_d;
  logic        ack_q;      // Acknowledge owed in the coming ninth pulse.
  logic        ack_d;
  logic        oe_q;       // Data line pulled low.
  logic        oe_d;
  logic        busy_q;     // Bus occupied.
  logic        busy_d;
  logic [7:0]  addr_q;     // Selected register index.
  logic [7:0]  addr_d;
  logic [7:0]  wdata_q;    // Last byte written.
  logic [7:0]  wdata_d;
  logic        wr_q;       // One cycle write strobe.
  logic        wr_d;

  // Next state of the engine. Start and stop outrank bit events because a
  // start can only follow a clock rise that has already been processed.
  always_comb begin
    phase_d = phase_q;
    cnt_d   = cnt_q;
    rx_d    = rx_q;
    tx_d    = tx_q;
    ack_d   = ack_q;
    oe_d    = oe_q;
    busy_d  = busy_q;
    addr_d  = addr_q;
    wdata_d = wdata_q;
    wr_d    = 1'b0;
    rx_byte = {rx_q[BYTE_BITS-2:0], bit_link.bit_val};
    if (start_evt) begin
      busy_d  = 1'b1;
      phase_d = IRWT_ADDR;
      cnt_d   = CNT_ZERO;
      ack_d   = 1'b0;
      oe_d    = 1'b0;
    end else if (stop_evt) begin
      busy_d  = 1'b0;
      phase_d = IRWT_IDLE;
      cnt_d   = CNT_ZERO;
      ack_d   = 1'b0;
      oe_d    = 1'b0;
    end else if (rise_evt && phase_q != IRWT_IDLE) begin
      if (cnt_q == CNT_ACK_SLOT) begin
        // Ninth pulse: the byte is closed and a new one begins.
        cnt_d = CNT_ZERO;
        ack_d = 1'b0;
        if (phase_q == IRWT_READ) begin
          if (bit_link.bit_val) begin
            phase_d = IRWT_IGNORE;
          end else begin
            tx_d = reg_rdata;
          end
        end
      end else begin
        rx_d  = rx_byte;
        tx_d  = {tx_q[BYTE_BITS-2:0], 1'b0};
        cnt_d = cnt_q + CNT_STEP;
        if (cnt_q == CNT_LAST_BIT) begin
          unique case (phase_q)
            IRWT_ADDR: begin
              if (rx_byte == ADDR_BYTE_WR) begin
                phase_d = IRWT_INDEX;
                ack_d   = 1'b1;
              end else if (rx_byte == ADDR_BYTE_RD) begin
                phase_d = IRWT_READ;
                ack_d   = 1'b1;
                tx_d    = reg_rdata;
              end else begin
                phase_d = IRWT_IGNORE;
              end
            end
            IRWT_INDEX: begin
              addr_d  = rx_byte;
              ack_d   = 1'b1;
              phase_d = IRWT_DATA;
            end
            IRWT_DATA: begin
              wdata_d = rx_byte;
              wr_d    = 1'b1;
              ack_d   = 1'b1;
            end
            IRWT_IDLE, IRWT_READ, IRWT_IGNORE: begin
              // The master owns the acknowledge of read bytes.
              ack_d = 1'b0;
            end
          endcase
        end
      end
    end else if (fall_evt) begin
      if (cnt_q == CNT_ACK_SLOT) begin
        oe_d = ack_q;
      end else if (phase_q == IRWT_READ) begin
        // Open drain: a zero bit pulls, a one bit releases.
        oe_d = ~tx_q[BYTE_BITS-1];
      end else begin
        oe_d = 1'b0;
      end
    end
  end

  // Engine registers. Write data persist so the strobe can be widened later
  // without changing the captured byte.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      phase_q <= IRWT_IDLE;
      cnt_q   <= CNT_ZERO;
      rx_q    <= BYTE_RESET;
      tx_q    <= BYTE_RESET;
      ack_q   <= 1'b0;
      oe_q    <= 1'b0;
      busy_q  <= 1'b0;
      addr_q  <= BYTE_RESET;
      wdata_q <= BYTE_RESET;
      wr_q    <= 1'b0;
    end else begin
      phase_q <= phase_d;
      cnt_q   <= cnt_d;
      rx_q    <= rx_d;
      tx_q    <= tx_d;
      ack_q   <= ack_d;
      oe_q    <= oe_d;
      busy_q  <= busy_d;
      addr_q  <= addr_d;
      wdata_q <= wdata_d;
      wr_q    <= wr_d;
    end
  end

  // Pin output level.

  logic sda_o_q;   // Driven level of the open drain pin, always low.
  logic sda_o_d;

  // An open drain pin only ever pulls low; the enable decides the line.
  always_comb begin
    sda_o_d = 1'b0;
  end

  // Kept as a flop so that every output leaves from a register.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sda_o_q <= 1'b0;
    end else begin
      sda_o_q <= sda_o_d;
    end
  end

  // Outputs. The enable reacts two to three mclk cycles after the clock
  // falls, well inside the shortest low phase at standard or fast rates.
  assign sda_o     = sda_o_q;
  assign sda_oe    = oe_q;
  assign bus_busy  = busy_q;
  assign reg_addr  = addr_q;
  assign reg_wdata = wdata_q;
  assign reg_wr    = wr_q;

endmodule // irwt_target

// ==== irwt_target_assertions.sv ====
// Checker for the two-wire target, watching only the top ports.
// Assumes mclk samples the serial pins often enough to see each edge.
module irwt_target_checker (
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic       scl,
  input wire logic       sda_i,
  input wire logic       sda_o,
  input wire logic       sda_oe,
  input wire logic       bus_busy,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_rdata
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Data edges while the clock is high on two samples, so a clock edge is not misread.
  sequence s_start;
    $fell(sda_i) && scl && $past(scl);
  endsequence
  sequence s_stop;
    $rose(sda_i) && scl && $past(scl);
  endsequence
  AST_START_BUSY: assert property (s_start |-> ##[1:6] bus_busy)
    else $error("bus not busy after start");
  AST_STOP_FREE: assert property (s_stop |-> ##[1:6] !bus_busy)
    else $error("bus still busy after stop");
  AST_IDLE_NO_DRIVE: assert property (!bus_busy |-> !sda_oe)
    else $error("data driven while bus idle");
  AST_OE_SCL_LOW: assert property ($changed(sda_oe) |-> !scl)
    else $error("data drive changed with clock high");
  AST_ACK_HOLD: assert property ($rose(sda_oe) |-> sda_oe [*8])
    else $error("pull-down too short");
  AST_PULL_LOW: assert property (sda_oe |-> !sda_o)
    else $error("driven data level not low");
  AST_WR_PULSE: assert property ($rose(reg_wr) |=> !reg_wr)
    else $error("write strobe longer than one cycle");
  AST_WR_BUSY: assert property (reg_wr |-> bus_busy && $stable(reg_addr))
    else $error("write outside a session or index moving");
  AST_WDATA_WR: assert property ($changed(reg_wdata) |-> reg_wr)
    else $error("write data changed without strobe");
  AST_ADDR_BUSY: assert property ($changed(reg_addr) |-> bus_busy)
    else $error("index changed outside a session");
endmodule // irwt_target_checker

bind irwt_target irwt_target_checker i_irwt_target_checker (.mclk(mclk), .rst_n(rst_n), .scl(scl),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .bus_busy(bus_busy), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata));

// ==== irwt_master_model.sv ====
// Behavioural bus master that frames sessions and clocks bytes.
// Assumes a pull-up on the data line; the clock stands high between frames.
module irwt_master_model (
  output logic      scl,      // Serial clock, idle high.
  output logic      sda_pull, // High while the master pulls data low.
  input  wire logic sda       // Resolved data line.
);
  timeunit 1ns;
  timeprecision 1ns;
  logic lclk = 1'b0; // Link timebase of 64 ns, phase unrelated to mclk.
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  always #32 lclk = ~lclk;
  // A quarter bit; long low phases leave the target time to move its pull-down.
  task automatic q();
    repeat (4) @(posedge lclk);
  endtask
  // master makes start, also repeated start from a low clock.
  task automatic start();
    sda_pull <= 1'b0;
    q();
    scl <= 1'b1;
    q();
    sda_pull <= 1'b1;
    q();
    scl <= 1'b0;
    q();
  endtask
  task automatic stop();
    sda_pull <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    sda_pull <= 1'b0;
    q();
  endtask
  // data set while the clock is low, sampled mid-high.
  task automatic clk_bit(input logic b, output logic s);
    sda_pull <= !b;
    q();
    scl <= 1'b1;
    q();
    s = sda;
    q();
    scl <= 1'b0;
    q();
  endtask
  // eight bits MSB first, then a ninth pulse with ack_in placed.
  task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack_out);
    for (int i = 7; i >= 0; i--) begin
      clk_bit(tx[i], rx[i]);
    end
    clk_bit(ack_in, ack_out);
  endtask
endmodule // irwt_master_model

// ==== test_i2c_register_write_target.sv ====
// Self-checking bench for the two-wire register target.
// Assumes the target and the master model; the bench holds the register store.
module test_i2c_register_write_target import irwt_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ns;
  logic       mclk = 1'b0;  // Core clock, 40 ns.
  logic       rst_n = 1'b0; // Synchronous reset, active low.
  logic       scl, m_pull, sda, sda_o, sda_oe, bus_busy, reg_wr, ack;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rx;
  logic [7:0] mem [256];     // Register store behind the target.
  logic [7:0] exp_mem [256]; // Expected store contents.
  logic [31:0] r;            // Random draw.
  int         fail_count = 0, checks_done = 0, seed = 10, wr_cnt = 0;
  always #20 mclk = ~mclk;
  // Open-drain wire: the target's pin level counts while its enable is high,
  // the master pulls low, and the pull-up wins otherwise.
  assign sda = (sda_oe ? sda_o : 1'b1) & !m_pull;
  assign reg_rdata = mem[reg_addr];
  // Store writes land here and are counted so stray writes show.
  always @(posedge mclk) begin
    if (reg_wr) begin
      mem[reg_addr] <= reg_wdata;
      wr_cnt <= wr_cnt + 1;
    end
  end
  irwt_target i_irwt_target (.mclk(mclk), .rst_n(rst_n), .scl(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .bus_busy(bus_busy), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata));
  irwt_master_model i_m (.scl(scl), .sda_pull(m_pull), .sda(sda));
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t byte %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t bit %b expected %b", $time, got, exp);
    end
  endtask
  // Only the fixed target address is acknowledged, low meaning ack.
  function automatic logic exp_ack(input logic [7:0] a);
    return (a[7:1] == TARGET_ADDR) ? 1'b0 : 1'b1;
  endfunction
  task automatic send(input logic [7:0] b, input logic e);
    i_m.xfer(b, 1'b1, rx, ack);
    chk_bit(ack, e);
  endtask
  task automatic wr_txn(input logic [7:0] idx, input logic [7:0] d1, input logic [7:0] d2);
    int n;
    n = wr_cnt;
    i_m.start();
    send(ADDR_BYTE_WR, 1'b0);
    send(idx, 1'b0);
    send(d1, 1'b0);
    send(d2, 1'b0);
    chk_bit(bus_busy, 1'b1);
    i_m.stop();
    repeat (8) @(posedge mclk);
    chk_bit(bus_busy, 1'b0);
    exp_mem[idx] = d2;
    chk_byte(reg_addr, idx);
    chk_byte(reg_wdata, d2);
    chk_bit(wr_cnt == n + 2, 1'b1);
    chk_byte(mem[idx], exp_mem[idx]);
  endtask
  // Read goes through a repeated start; the master acks once, then refuses.
  task automatic rd_txn(input logic [7:0] idx);
    i_m.start();
    send(ADDR_BYTE_WR, 1'b0);
    send(idx, 1'b0);
    i_m.start();
    send(ADDR_BYTE_RD, 1'b0);
    i_m.xfer(8'hff, 1'b0, rx, ack);
    chk_byte(rx, exp_mem[idx]);
    i_m.xfer(8'hff, 1'b1, rx, ack);
    chk_byte(rx, exp_mem[idx]);
    i_m.stop();
  endtask
  // A foreign address must get no ack and cause no write.
  task automatic bad_txn();
    int n;
    n = wr_cnt;
    r = $random(seed);
    if (r[7:1] == TARGET_ADDR) begin
      r[7] = ~r[7];
    end
    i_m.start();
    send(r[7:0], exp_ack(r[7:0]));
    send(r[15:8], 1'b1);
    i_m.stop();
    repeat (8) @(posedge mclk);
    chk_bit(wr_cnt == n, 1'b1);
  endtask
  task automatic test_done();
    $display("checks %0d failures %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Hang guard, well beyond the expected half millisecond of traffic.
  initial begin
    #2000000;
    fail_count++;
    test_done();
  end
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'h00;
      exp_mem[i] = 8'h00;
    end
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    wr_txn(8'h00, 8'hff, 8'h00);
    wr_txn(8'hff, 8'h00, 8'hff);
    repeat (4) begin
      r = $random(seed);
      wr_txn(r[7:0], r[15:8], r[23:16]);
    end
    // Address cut short after four bits, then restarted.
    i_m.start();
    for (int k = 7; k > 3; k--) begin
      i_m.clk_bit(ADDR_BYTE_WR[k], ack);
    end
    wr_txn(r[31:24], r[7:0], r[15:8]);
    rd_txn(8'hff);
    rd_txn(r[31:24]);
    bad_txn();
    bad_txn();
    test_done();
  end
endmodule // test_i2c_register_write_target
